// >>> recorder_seq_pkg.sv
// Notes on behaviour
// - All sequencer delays scale with sampling period
// - Reset execution takes 125 us
// - Pause pulse enters pause within 250 us
// - Start while paused resumes within 500 us
// - Power-down low: start waits 32 ms oscillator
// - Power-down low: record stop drops monitor 1 ms
// - Power-down low: playback stop drops monitor 256 ms
// - Power-down low: 64 ms transient at playback start
// - Power-down low: 256 ms transient at playback end
// - Power-down low: 70 us to power-down after playback
// - Power-down low: stop in pause ends record 1 ms, playback 256 ms
// - Power-down high: start raises monitor within 1 ms
// - Power-down high: voice trigger standby within 1 ms
// - Power-down high: stop in pause ends within 1 ms
// - Busy held 125 us after reset release
// - One-nibble command busy 16 us; host waits
// - Two-nibble command and data busy 16 us each
// - Address-write command busy up to 270 us
// - Address-write data nibble busy up to 50 us
// - Host waits 270 us before first address read
// - Host spaces address reads 50 us apart
// - Monitor high while active, pausing, paused, resuming or stopping
// - Chip enable high blocks strobes and data
package recorder_seq_pkg;
  localparam int unsigned CLK_PERIOD_NS     = 10;
  localparam int unsigned REF_SAMP_HZ       = 8000;
  localparam int unsigned REF_US_PER_SAMPLE = 125;
  // One tick is one microsecond at the reference sampling rate
  localparam int unsigned DEF_TICK_CYCLES   = (1_000_000_000 / REF_SAMP_HZ) / REF_US_PER_SAMPLE / CLK_PERIOD_NS;
  localparam int unsigned DLY_W             = 19;

  localparam int unsigned T_REX_US  = 125;
  localparam int unsigned T_PP_US   = 250;
  localparam int unsigned T_PSP_US  = 500;
  localparam int unsigned T_ANA_US  = 32000;
  localparam int unsigned T_SPM1_US = 1000;
  localparam int unsigned T_AOR_US  = 64000;
  localparam int unsigned T_AOF_US  = 256000;
  localparam int unsigned T_MS_US   = 70;
  localparam int unsigned T_STM_US  = 1000;
  localparam int unsigned T_SPV_US  = 500;
  localparam int unsigned T_B1_US   = 16;
  localparam int unsigned T_BAW_US  = 270;
  localparam int unsigned T_BAD_US  = 50;
  localparam int unsigned T_WAR_US  = 270;
  localparam int unsigned T_WDR_US  = 50;

  localparam int unsigned T_STROBE_NS = 200;
  localparam int unsigned T_DRW_NS    = 250;
  localparam int unsigned STROBE_CYC  = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DRW_CYC     = (T_DRW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [3:0] CMD_START    = 4'h1;
  localparam logic [3:0] CMD_STOP     = 4'h2;
  localparam logic [3:0] CMD_PAUSE    = 4'h3;
  localparam logic [3:0] CMD_OPTION   = 4'h4;
  localparam logic [3:0] CMD_ADDR_WR  = 4'h5;
  localparam logic [3:0] CMD_ADDR_RD  = 4'h6;
  localparam logic [1:0] ADDR_NIBBLES = 2'd3;
  localparam logic [3:0] STATUS_RESET = 4'h8;

  typedef enum logic [2:0] {
    K_WRITE1  = 3'd0,
    K_WRITE2  = 3'd1,
    K_ADDR_WR = 3'd2,
    K_ADDR_RD = 3'd3,
    K_STATUS  = 3'd4
  } req_kind_t;
endpackage : recorder_seq_pkg

// >>> recorder_link_if.sv
`timescale 1ns/1ps
interface recorder_link_if;
  logic       ce_n;
  logic       wr_n;
  logic       rd_n;
  logic [3:0] host_d;
  logic       host_d_oe;
  logic [3:0] dev_d;
  logic       dev_d_oe;
  logic       busy;
  logic [3:0] data;

  // Bus level resolved from the enables; an undriven bus reads as zero
  assign data = dev_d_oe ? dev_d : (host_d_oe ? host_d : 4'h0);

  modport dev (
    input  ce_n, wr_n, rd_n, data,
    output dev_d, dev_d_oe, busy
  );
  modport host (
    input  busy, data,
    output ce_n, wr_n, rd_n, host_d, host_d_oe
  );
endinterface : recorder_link_if

// >>> recorder_seq_dev.sv
`timescale 1ns/1ps
module recorder_seq_dev #(
  parameter int unsigned TICK_CYCLES = recorder_seq_pkg::DEF_TICK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic        mcu_mode,
  input  wire logic        start_pulse_in_n,
  input  wire logic        stop_pulse_in_n,
  input  wire logic        pause_pulse_in_n,
  input  wire logic        powerdown_select,
  input  wire logic        record_select,
  input  wire logic        voice_trigger_en,
  input  wire logic        voice_detected,
  output logic             activity_monitor_out,
  output logic             paused_out,
  output logic             voice_standby_out,
  output logic [3:0]       option_nibble_out,
  output logic [11:0]      address_out,
  recorder_link_if.dev     link
);
  import recorder_seq_pkg::*;

  typedef enum logic [11:0] {
    S_RESET   = 12'b0000_0000_0001,
    S_IDLE    = 12'b0000_0000_0010,
    S_OSC     = 12'b0000_0000_0100,
    S_START   = 12'b0000_0000_1000,
    S_VSTBY   = 12'b0000_0001_0000,
    S_VREL    = 12'b0000_0010_0000,
    S_ACTIVE  = 12'b0000_0100_0000,
    S_PAUSING = 12'b0000_1000_0000,
    S_PAUSED  = 12'b0001_0000_0000,
    S_RESUME  = 12'b0010_0000_0000,
    S_STOP    = 12'b0100_0000_0000,
    S_PWRDN   = 12'b1000_0000_0000
  } seq_state_t;

  seq_state_t       st_q, st_d;
  logic [15:0]      pre_q;
  logic             tick;
  logic [DLY_W-1:0] tmr_q, ld_val;
  logic             ld;
  logic             tmr_done;
  logic [8:0]       busy_q;
  logic             rec_q;
  logic [2:0]       pin_q;
  logic             wr_q, rd_q;
  logic             wr_take, rd_done;
  logic [1:0]       pend_q, rdn_q;
  logic             addr_mode_q;
  logic             cmd_start, cmd_stop, cmd_pause;
  logic             start_ev, stop_ev, pause_ev;
  logic             busy;
  logic [3:0]       dd_q;

  // Tick prescaler: changing TICK_CYCLES with the sampling rate rescales every delay
  assign tick = (pre_q == 16'(TICK_CYCLES - 1));
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      pre_q <= 16'h0000;
    else if (clk_en)
      pre_q <= tick ? 16'h0000 : pre_q + 16'h0001;
  end

  assign tmr_done = (tmr_q == '0);
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      tmr_q <= DLY_W'(T_REX_US);
    else if (clk_en)
    begin
      if (ld)
        tmr_q <= ld_val;
      else if (tick && !tmr_done)
        tmr_q <= tmr_q - 1'b1;
    end
  end

  // Pins are active-low pulses, taken on their falling edge; ignored in command mode
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      pin_q <= 3'b111;
    else if (clk_en)
      pin_q <= {start_pulse_in_n, stop_pulse_in_n, pause_pulse_in_n};
  end

  assign start_ev = cmd_start | (!mcu_mode & pin_q[2] & !start_pulse_in_n);
  assign stop_ev  = cmd_stop  | (!mcu_mode & pin_q[1] & !stop_pulse_in_n);
  assign pause_ev = cmd_pause | (!mcu_mode & pin_q[0] & !pause_pulse_in_n);

  always_comb
  begin
    st_d   = st_q;
    ld     = 1'b0;
    ld_val = '0;
    unique case (st_q)
      S_RESET:
        if (tmr_done)
          st_d = S_IDLE;
      S_IDLE:
        if (start_ev)
        begin
          ld = 1'b1;
          if (!powerdown_select)
          begin
            st_d   = S_OSC;
            ld_val = DLY_W'(T_ANA_US);
          end
          else
          begin
            st_d   = S_START;
            ld_val = DLY_W'(T_STM_US);
          end
        end
      S_OSC:
        if (tmr_done)
        begin
          st_d   = S_START;
          ld     = 1'b1;
          ld_val = rec_q ? DLY_W'(T_STM_US) : DLY_W'(T_AOR_US);
        end
      S_START:
        if (tmr_done)
          st_d = voice_trigger_en ? S_VSTBY : S_ACTIVE;
      S_VSTBY:
        if (stop_ev)
        begin
          st_d   = S_VREL;
          ld     = 1'b1;
          ld_val = DLY_W'(T_SPV_US);
        end
        else if (voice_detected)
          st_d = S_ACTIVE;
      S_VREL:
        if (tmr_done)
          st_d = S_IDLE;
      S_ACTIVE, S_PAUSED:
        if (stop_ev)
        begin
          st_d   = S_STOP;
          ld     = 1'b1;
          // Playback with power-down waits for the output transient before the monitor falls
          ld_val = (!powerdown_select && !rec_q) ? DLY_W'(T_AOF_US) : DLY_W'(T_SPM1_US);
        end
        else if (st_q == S_ACTIVE && pause_ev)
        begin
          st_d   = S_PAUSING;
          ld     = 1'b1;
          ld_val = DLY_W'(T_PP_US);
        end
        else if (st_q == S_PAUSED && start_ev)
        begin
          st_d   = S_RESUME;
          ld     = 1'b1;
          ld_val = DLY_W'(T_PSP_US);
        end
      S_PAUSING:
        if (tmr_done)
          st_d = S_PAUSED;
      S_RESUME:
        if (tmr_done)
          st_d = S_ACTIVE;
      S_STOP:
        if (tmr_done)
        begin
          if (!powerdown_select && !rec_q)
          begin
            st_d   = S_PWRDN;
            ld     = 1'b1;
            ld_val = DLY_W'(T_MS_US);
          end
          else
            st_d = S_IDLE;
        end
      S_PWRDN:
        if (tmr_done)
          st_d = S_IDLE;
      default:
        st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      st_q <= S_RESET;
    else if (clk_en)
      st_q <= st_d;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rec_q <= 1'b0;
    else if (clk_en && st_q == S_IDLE && start_ev)
      rec_q <= record_select;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      activity_monitor_out <= 1'b0;
      paused_out           <= 1'b0;
      voice_standby_out    <= 1'b0;
    end
    else if (clk_en)
    begin
      activity_monitor_out <= st_d inside {S_ACTIVE, S_PAUSING, S_PAUSED, S_RESUME, S_STOP};
      paused_out           <= (st_d == S_PAUSED);
      voice_standby_out    <= (st_d == S_VSTBY);
    end
  end

  // Strobes count only while chip enable is low; write data is taken at the rising edge
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_q <= 1'b1;
      rd_q <= 1'b1;
    end
    else if (clk_en)
    begin
      wr_q <= link.wr_n;
      rd_q <= link.rd_n;
    end
  end

  assign busy    = (busy_q != 9'h000) || (st_q == S_RESET);
  assign wr_take = mcu_mode && !link.ce_n && !wr_q && link.wr_n && !busy;
  assign rd_done = mcu_mode && !link.ce_n && !rd_q && link.rd_n;

  assign cmd_start = wr_take && pend_q == 2'd0 && link.data == CMD_START;
  assign cmd_stop  = wr_take && pend_q == 2'd0 && link.data == CMD_STOP;
  assign cmd_pause = wr_take && pend_q == 2'd0 && link.data == CMD_PAUSE;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      busy_q <= 9'h000;
    else if (clk_en)
    begin
      if (wr_take)
      begin
        if (pend_q != 2'd0)
          busy_q <= addr_mode_q ? 9'(T_BAD_US) : 9'(T_B1_US);
        else if (link.data == CMD_ADDR_WR)
          busy_q <= 9'(T_BAW_US);
        else
          busy_q <= 9'(T_B1_US);
      end
      else if (tick && busy_q != 9'h000)
        busy_q <= busy_q - 9'h001;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pend_q            <= 2'd0;
      addr_mode_q       <= 1'b0;
      option_nibble_out <= 4'h0;
      address_out       <= 12'h000;
      rdn_q             <= 2'd0;
    end
    else if (clk_en)
    begin
      if (wr_take)
      begin
        if (pend_q != 2'd0)
        begin
          pend_q <= pend_q - 2'd1;
          if (addr_mode_q)
            address_out <= {link.data, address_out[11:4]};
          else
            option_nibble_out <= link.data;
        end
        else
        begin
          rdn_q <= (link.data == CMD_ADDR_RD) ? ADDR_NIBBLES : 2'd0;
          if (link.data == CMD_OPTION)
          begin
            pend_q      <= 2'd1;
            addr_mode_q <= 1'b0;
          end
          else if (link.data == CMD_ADDR_WR)
          begin
            pend_q      <= ADDR_NIBBLES;
            addr_mode_q <= 1'b1;
          end
        end
      end
      else if (rd_done && rdn_q != 2'd0)
        rdn_q <= rdn_q - 2'd1;
    end
  end

  // Read data is registered so the bus sees no decode glitches
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      dd_q <= STATUS_RESET;
    else if (clk_en)
    begin
      unique case (rdn_q)
        2'd3:    dd_q <= address_out[3:0];
        2'd2:    dd_q <= address_out[7:4];
        2'd1:    dd_q <= address_out[11:8];
        default: dd_q <= {busy, activity_monitor_out, paused_out, voice_standby_out};
      endcase
    end
  end

  assign link.dev_d    = dd_q;
  assign link.dev_d_oe = mcu_mode && !link.ce_n && !link.rd_n;
  assign link.busy     = busy;
endmodule : recorder_seq_dev

// >>> recorder_seq_host.sv
`timescale 1ns/1ps
module recorder_seq_host #(
  parameter int unsigned RD_FIRST_CYC = recorder_seq_pkg::T_WAR_US * recorder_seq_pkg::DEF_TICK_CYCLES,
  parameter int unsigned RD_NEXT_CYC  = recorder_seq_pkg::T_WDR_US * recorder_seq_pkg::DEF_TICK_CYCLES
) (
  input  wire logic                        clk,
  input  wire logic                        reset_n,
  input  wire logic                        clk_en,
  input  wire logic                        req_valid,
  input  wire recorder_seq_pkg::req_kind_t req_kind,
  input  wire logic [3:0]                  req_cmd,
  input  wire logic [11:0]                 req_data,
  output logic                             req_ready,
  output logic                             rsp_valid,
  output logic [11:0]                      rsp_data,
  recorder_link_if.host                    link
);
  import recorder_seq_pkg::*;

  typedef enum logic [5:0] {
    H_IDLE   = 6'b00_0001,
    H_BWAIT  = 6'b00_0010,
    H_STROBE = 6'b00_0100,
    H_GAP    = 6'b00_1000,
    H_RWAIT  = 6'b01_0000,
    H_READ   = 6'b10_0000
  } host_state_t;

  host_state_t st_q;
  logic [19:0] cnt_q;
  logic [15:0] nib_q;
  logic [2:0]  wleft_q;
  logic [1:0]  rleft_q;
  logic        is_stat_q;

  assign req_ready = (st_q == H_IDLE);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_q      <= H_IDLE;
      cnt_q     <= 20'h0_0000;
      nib_q     <= 16'h0000;
      wleft_q   <= 3'd0;
      rleft_q   <= 2'd0;
      is_stat_q <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data  <= 12'h000;
      link.ce_n      <= 1'b1;
      link.wr_n      <= 1'b1;
      link.rd_n      <= 1'b1;
      link.host_d    <= 4'h0;
      link.host_d_oe <= 1'b0;
    end
    else if (clk_en)
    begin
      rsp_valid <= 1'b0;
      unique case (st_q)
        H_IDLE:
          if (req_valid)
          begin
            nib_q     <= {req_data, req_cmd};
            is_stat_q <= (req_kind == K_STATUS);
            link.ce_n <= 1'b0;
            unique case (req_kind)
              K_WRITE1:  begin wleft_q <= 3'd1; rleft_q <= 2'd0; st_q <= H_BWAIT; end
              K_WRITE2:  begin wleft_q <= 3'd2; rleft_q <= 2'd0; st_q <= H_BWAIT; end
              K_ADDR_WR: begin wleft_q <= 3'd4; rleft_q <= 2'd0; st_q <= H_BWAIT; end
              K_ADDR_RD: begin wleft_q <= 3'd1; rleft_q <= ADDR_NIBBLES; st_q <= H_BWAIT; end
              default:   begin wleft_q <= 3'd0; rleft_q <= 2'd1; cnt_q <= 20'(STROBE_CYC - 1);
                               link.rd_n <= 1'b0; st_q <= H_READ; end
            endcase
          end
        H_BWAIT:
          // A new nibble only goes out once the device has dropped busy
          if (!link.busy)
          begin
            link.wr_n      <= 1'b0;
            link.host_d    <= nib_q[3:0];
            link.host_d_oe <= 1'b1;
            cnt_q          <= 20'(STROBE_CYC - 1);
            st_q           <= H_STROBE;
          end
        H_STROBE:
          if (cnt_q == 20'h0_0000)
          begin
            link.wr_n <= 1'b1;
            cnt_q     <= 20'(DRW_CYC - 1);
            nib_q     <= {4'h0, nib_q[15:4]};
            wleft_q   <= wleft_q - 3'd1;
            st_q      <= H_GAP;
          end
          else
            cnt_q <= cnt_q - 20'h0_0001;
        H_GAP:
          if (cnt_q == 20'h0_0000)
          begin
            link.host_d_oe <= 1'b0;
            if (wleft_q != 3'd0)
              st_q <= H_BWAIT;
            else if (rleft_q != 2'd0)
            begin
              cnt_q <= 20'(RD_FIRST_CYC - 1);
              st_q  <= H_RWAIT;
            end
            else
            begin
              link.ce_n <= 1'b1;
              rsp_valid <= 1'b1;
              st_q      <= H_IDLE;
            end
          end
          else
            cnt_q <= cnt_q - 20'h0_0001;
        H_RWAIT:
          if (cnt_q == 20'h0_0000)
          begin
            link.rd_n <= 1'b0;
            cnt_q     <= 20'(STROBE_CYC - 1);
            st_q      <= H_READ;
          end
          else
            cnt_q <= cnt_q - 20'h0_0001;
        H_READ:
          if (cnt_q == 20'h0_0000)
          begin
            link.rd_n <= 1'b1;
            rleft_q   <= rleft_q - 2'd1;
            if (is_stat_q)
              rsp_data <= {8'h00, link.data};
            else
              rsp_data <= {link.data, rsp_data[11:4]};
            if (rleft_q == 2'd1)
            begin
              link.ce_n <= 1'b1;
              rsp_valid <= 1'b1;
              st_q      <= H_IDLE;
            end
            else
            begin
              // Counted from the strobe's rise, so the idle gap alone meets the minimum
              cnt_q <= 20'(RD_NEXT_CYC - 1);
              st_q  <= H_RWAIT;
            end
          end
          else
            cnt_q <= cnt_q - 20'h0_0001;
        default:
          st_q <= H_IDLE;
      endcase
    end
  end
endmodule : recorder_seq_host

// >>> recorder_link_sva.sv
`timescale 1ns/1ps
module recorder_link_sva #(
  parameter int unsigned TICK_CYCLES = recorder_seq_pkg::DEF_TICK_CYCLES
) (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       ce_n,
  input wire logic       wr_n,
  input wire logic       rd_n,
  input wire logic       host_d_oe,
  input wire logic       dev_d_oe,
  input wire logic       busy,
  input wire logic [3:0] data
);
  import recorder_seq_pkg::*;

  logic        wr_q;
  logic        rd_q;
  logic [1:0]  nib_q;
  logic [1:0]  left_q;
  int unsigned lim_q;
  int unsigned run_q;
  int unsigned gap_q;
  int unsigned age_q;
  logic        take;

  // A write counts only where the device would take it, so refused strobes set no limit
  assign take = wr_n && !wr_q && !ce_n && !busy;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_q  <= 1'b1;
      rd_q  <= 1'b1;
      run_q <= 0;
      gap_q <= 0;
      age_q <= 0;
    end
    else
    begin
      wr_q  <= wr_n;
      rd_q  <= rd_n;
      run_q <= busy ? run_q + 1 : 0;
      gap_q <= (take || (rd_n && !rd_q)) ? 0 : gap_q + 1;
      age_q <= (age_q < 100000) ? age_q + 1 : age_q;
    end
  end

  // Busy limit for the interval that follows the last accepted write; gap_q lags its strobe by one edge
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lim_q  <= T_REX_US * TICK_CYCLES;
      nib_q  <= 2'd0;
      left_q <= 2'd0;
    end
    else if (take)
    begin
      if (nib_q != 2'd0)
      begin
        nib_q <= nib_q - 2'd1;
        lim_q <= T_BAD_US * TICK_CYCLES;
      end
      else if (data == CMD_ADDR_WR)
      begin
        nib_q <= ADDR_NIBBLES;
        lim_q <= T_BAW_US * TICK_CYCLES;
      end
      else
      begin
        lim_q <= T_B1_US * TICK_CYCLES;
      end
      if (nib_q == 2'd0 && data == CMD_ADDR_RD)
        left_q <= 2'd3;
    end
    else if (rd_n && !rd_q && left_q != 2'd0)
      left_q <= left_q - 2'd1;
  end

  oe_needs_ce_a: assert property (@(posedge clk) disable iff (!reset_n) dev_d_oe |-> !ce_n && !rd_n)
    else $error("device drives data while not selected");
  single_driver_a: assert property (@(posedge clk) disable iff (!reset_n) !(dev_d_oe && host_d_oe))
    else $error("both ends drive the data bus");
  wr_idle_a: assert property (@(posedge clk) disable iff (!reset_n) $fell(wr_n) && !ce_n |-> !busy)
    else $error("write strobe started while busy");
  busy_answer_a: assert property (@(posedge clk) disable iff (!reset_n) take |=> busy)
    else $error("busy did not follow an accepted write");
  busy_bound_a: assert property (@(posedge clk) disable iff (!reset_n) busy |-> run_q <= lim_q)
    else $error("busy held beyond its limit");
  rd_first_a: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(rd_n) && left_q == 2'd3 |-> gap_q >= T_WAR_US * TICK_CYCLES)
    else $error("first address read too soon");
  rd_next_a: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(rd_n) && left_q != 2'd0 && left_q != 2'd3 |-> gap_q >= T_WDR_US * TICK_CYCLES - 1)
    else $error("address reads too close");
  reset_exec_a: assert property (@(posedge clk) disable iff (!reset_n)
    age_q < (T_REX_US - 1) * TICK_CYCLES |-> busy)
    else $error("reset execution ended early");
endmodule : recorder_link_sva

// >>> voice_recorder_control_sequencer_test.sv
`timescale 1ns/1ps
module test_voice_recorder_control_sequencer;
  import recorder_seq_pkg::*;
  localparam int unsigned TICK = 2;
  localparam int unsigned SLACK = 8;

  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        mcu_mode = 1'b1;
  logic        start_n = 1'b1;
  logic        stop_n = 1'b1;
  logic        pause_n = 1'b1;
  logic        pd_sel = 1'b1;
  logic        rec_sel = 1'b1;
  logic        vt_en = 1'b0;
  logic        req_valid = 1'b0;
  req_kind_t   req_kind = K_STATUS;
  logic [3:0]  req_cmd = 4'h0;
  logic [11:0] req_data = 12'h000;
  logic        req_ready;
  logic        rsp_valid;
  logic [11:0] rsp_data;
  logic        activity_monitor_out;
  logic        paused_out;
  logic        voice_standby_out;
  logic [3:0]  option_nibble_out;
  logic [11:0] address_out;
  logic [11:0] rsp;
  int          num_errors = 0;
  int          total_checks = 0;

  always #5 clk = ~clk;

  recorder_link_if link ();

  recorder_seq_dev #(.TICK_CYCLES(TICK)) recorder_seq_dev_inst (
    .clk(clk), .reset_n(reset_n), .clk_en(1'b1), .mcu_mode(mcu_mode),
    .start_pulse_in_n(start_n), .stop_pulse_in_n(stop_n), .pause_pulse_in_n(pause_n),
    .powerdown_select(pd_sel), .record_select(rec_sel), .voice_trigger_en(vt_en), .voice_detected(1'b0),
    .activity_monitor_out(activity_monitor_out), .paused_out(paused_out),
    .voice_standby_out(voice_standby_out), .option_nibble_out(option_nibble_out),
    .address_out(address_out), .link(link)
  );

  recorder_seq_host #(.RD_FIRST_CYC(T_WAR_US * TICK), .RD_NEXT_CYC(T_WDR_US * TICK)) recorder_seq_host_inst (
    .clk(clk), .reset_n(reset_n), .clk_en(1'b1), .req_valid(req_valid), .req_kind(req_kind),
    .req_cmd(req_cmd), .req_data(req_data), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .link(link)
  );

  recorder_link_sva #(.TICK_CYCLES(TICK)) recorder_link_sva_inst (
    .clk(clk), .reset_n(reset_n), .ce_n(link.ce_n), .wr_n(link.wr_n), .rd_n(link.rd_n),
    .host_d_oe(link.host_d_oe), .dev_d_oe(link.dev_d_oe), .busy(link.busy), .data(link.data)
  );

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  task automatic check(input string name, input logic [11:0] exp, input logic [11:0] got);
    total_checks++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask : check

  function automatic logic pick(input int sel);
    case (sel)
      0: return activity_monitor_out;
      1: return paused_out;
      2: return voice_standby_out;
      default: return link.busy;
    endcase
  endfunction : pick

  // Bounded wait; running out of the bound ends the run
  task automatic wait_level(input int sel, input logic lvl, input int unsigned limit, input string name);
    int unsigned n;
    n = 0;
    while (pick(sel) !== lvl && n < limit)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check(name, {11'd0, lvl}, {11'd0, pick(sel)});
    if (pick(sel) !== lvl)
      test_done();
  endtask : wait_level

  // Pulses are taken on their falling edge; the release comes later in the background
  task automatic pulse(input int sel);
    @(negedge clk);
    case (sel)
      0: start_n = 1'b0;
      1: stop_n = 1'b0;
      default: pause_n = 1'b0;
    endcase
    fork
      begin
        repeat (40 * TICK) @(negedge clk);
        start_n = 1'b1;
        stop_n = 1'b1;
        pause_n = 1'b1;
      end
    join_none
  endtask : pulse

  task automatic request(input req_kind_t kind, input logic [3:0] cmd, input logic [11:0] d);
    int unsigned n;
    n = 0;
    @(negedge clk);
    req_valid = 1'b1;
    req_kind = kind;
    req_cmd = cmd;
    req_data = d;
    while (req_ready !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    check("ready", 12'h001, {11'd0, req_ready});
    @(negedge clk);
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 5000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check("response", 12'h001, {11'd0, rsp_valid});
    if (rsp_valid !== 1'b1)
      test_done();
    rsp = rsp_data;
  endtask : request

  initial
  begin
    repeat (12) @(negedge clk);
    check("busy in reset", 12'h001, {11'd0, link.busy});
    reset_n = 1'b1;
    wait_level(3, 1'b0, T_REX_US * TICK + SLACK, "busy after reset");
    request(K_STATUS, 4'h0, 12'h000);
    check("idle status", 12'h000, rsp);
    request(K_WRITE2, CMD_OPTION, 12'h009);
    check("option nibble", 12'h009, {8'd0, option_nibble_out});
    request(K_ADDR_WR, CMD_ADDR_WR, 12'ha5c);
    check("address", 12'ha5c, address_out);
    request(K_ADDR_RD, CMD_ADDR_RD, 12'h000);
    check("address read", 12'ha5c, rsp);
    request(K_WRITE1, CMD_START, 12'h000);
    wait_level(0, 1'b1, T_STM_US * TICK + SLACK, "monitor on start");
    request(K_STATUS, 4'h0, 12'h000);
    check("active status", 12'h004, rsp);
    request(K_WRITE1, CMD_PAUSE, 12'h000);
    wait_level(1, 1'b1, T_PP_US * TICK + SLACK, "paused by command");
    request(K_WRITE1, CMD_STOP, 12'h000);
    wait_level(0, 1'b0, T_SPM1_US * TICK + SLACK, "monitor on stop");
    @(negedge clk);
    mcu_mode = 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      @(negedge clk);
      rec_sel = (i == 0);
      pulse(0);
      wait_level(0, 1'b1, T_STM_US * TICK + SLACK, "monitor rise");
      pulse(2);
      wait_level(1, 1'b1, T_PP_US * TICK + SLACK, "paused");
      check("monitor in pause", 12'h001, {11'd0, activity_monitor_out});
      pulse(0);
      wait_level(1, 1'b0, T_PSP_US * TICK + SLACK, "resumed");
      // Pause is only taken once the resume delay has run out
      repeat ((T_PSP_US + 1) * TICK) @(negedge clk);
      pulse(2);
      wait_level(1, 1'b1, T_PP_US * TICK + SLACK, "paused again");
      pulse(1);
      wait_level(0, 1'b0, T_STM_US * TICK + SLACK, "stop in pause");
    end
    @(negedge clk);
    vt_en = 1'b1;
    pulse(0);
    wait_level(2, 1'b1, T_STM_US * TICK + SLACK, "voice standby");
    check("monitor in standby", 12'h000, {11'd0, activity_monitor_out});
    pulse(1);
    wait_level(2, 1'b0, T_SPV_US * TICK + SLACK, "standby released");
    // Start is ignored until the standby release has run out
    repeat ((T_SPV_US + 1) * TICK) @(negedge clk);
    vt_en = 1'b0;
    pd_sel = 1'b0;
    rec_sel = 1'b1;
    pulse(0);
    repeat ((T_ANA_US - 1) * TICK) @(negedge clk);
    check("monitor during osc wait", 12'h000, {11'd0, activity_monitor_out});
    wait_level(0, 1'b1, (T_SPM1_US + 1) * TICK + SLACK, "monitor after osc");
    pulse(1);
    wait_level(0, 1'b0, T_SPM1_US * TICK + SLACK, "record stop");
    test_done();
  end
endmodule : test_voice_recorder_control_sequencer
